// file: mmu_access_protection_check.sv
// MMU access-protection and translation-fault check
`timescale 1ns/1ps
module mmu_access_protection_check
#(
   parameter int PID_WIDTH = mmu_prot_pkg::PID_W
)
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Machine state
   input wire logic interrupt_take_i,
   input wire logic relocate_wr_i,
   input wire logic instr_relocate_i,
   input wire logic data_relocate_i,
   input wire logic user_mode_flag_i,
   input wire logic user_attr_fault_enable_i,
   input wire logic [PID_WIDTH-1:0] current_process_id_i,
   output logic instr_relocate_o,
   output logic data_relocate_o,
   // Special-register port
   input wire logic spr_read_i,
   input wire logic spr_write_i,
   input wire logic [mmu_prot_pkg::SPR_NUM_W-1:0] spr_num_i,
   input wire logic [31:0] spr_wdata_i,
   output logic [31:0] spr_rdata_o,
   output logic spr_hit_o,
   // Data access with matched entry
   input wire logic d_req_i,
   input wire mmu_prot_pkg::data_op_t d_op_i,
   input wire logic d_hit_i,
   input wire logic [PID_WIDTH-1:0] d_entry_process_tag_i,
   input wire logic [31:0] d_entry_data_word_i,
   input wire logic [31:0] d_entry_tag_word_i,
   output logic d_go_o,
   output logic d_nop_o,
   output mmu_prot_pkg::data_fault_t d_fault_o,
   // Instruction fetch with matched entry
   input wire logic i_req_i,
   input wire logic i_hit_i,
   input wire logic [PID_WIDTH-1:0] i_entry_process_tag_i,
   input wire logic [31:0] i_entry_data_word_i,
   output logic i_go_o,
   output logic i_miss_o,
   output logic i_tag_fault_o,
   // Instruction execution
   input wire logic ex_valid_i,
   input wire logic ex_tag_fault_i,
   output logic instr_storage_fault_o
);
   import mmu_prot_pkg::*;

   zone_sel_if zone_index_field();

   logic instr_relocate_ff;
   logic data_relocate_ff;
   logic nxt_instr_relocate;
   logic nxt_data_relocate;
   logic [31:0] zone_reg;
   logic spr_sel;

   // Big-endian bit number to index
   function automatic logic be_bit(input logic [31:0] w, input int b);
      be_bit = w[31-b];
   endfunction

   function automatic logic tag_match(input logic [PID_WIDTH-1:0] tag,
      input logic [PID_WIDTH-1:0] current_process_id);
      tag_match = (tag == current_process_id) || (tag == PID_WIDTH'(GLOBAL_TAG));
   endfunction

   // Machine-state relocate flags
   always_comb
   begin
      nxt_instr_relocate = instr_relocate_ff;
      nxt_data_relocate = data_relocate_ff;
      if (interrupt_take_i)
      begin
         nxt_instr_relocate = 1'b0;
         nxt_data_relocate = 1'b0;
      end
      else if (relocate_wr_i)
      begin
         nxt_instr_relocate = instr_relocate_i;
         nxt_data_relocate = data_relocate_i;
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         instr_relocate_ff <= 1'b0;
         data_relocate_ff <= 1'b0;
      end
      else
      begin
         instr_relocate_ff <= nxt_instr_relocate;
         data_relocate_ff <= nxt_data_relocate;
      end
   end

   assign instr_relocate_o = instr_relocate_ff;
   assign data_relocate_o = data_relocate_ff;

   // Zone register, privileged access only
   assign spr_sel = (spr_num_i == ZONE_OVERRIDE_SPR) && !user_mode_flag_i;

   zone_override_file u_zone
   (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .spr_wr_i(spr_write_i && spr_sel),
      .spr_wdata_i(spr_wdata_i),
      .zone_reg_o(zone_reg),
      .zone_index_field(zone_index_field.provider)
   );

   assign spr_hit_o = (spr_read_i || spr_write_i) && spr_sel;
   assign spr_rdata_o = (spr_read_i && spr_sel) ? zone_reg : 32'h0;

   // Entry fields
   logic d_store_permit;
   logic d_user_attr;
   logic [1:0] d_zone;
   logic i_run_permit;
   logic i_spec_block;
   logic [1:0] i_zone;

   assign d_store_permit = be_bit(d_entry_data_word_i, STORE_PERMIT_BE);
   assign d_user_attr = be_bit(d_entry_tag_word_i, USER_ATTR_BE);
   assign zone_index_field.d_index = d_entry_data_word_i[31-ZONE_IDX_BE_MSB -: 4];
   assign zone_index_field.i_index = i_entry_data_word_i[31-ZONE_IDX_BE_MSB -: 4];
   assign d_zone = zone_index_field.d_zone;
   assign i_zone = zone_index_field.i_zone;
   assign i_run_permit = be_bit(i_entry_data_word_i, RUN_PERMIT_BE);
   assign i_spec_block = be_bit(i_entry_data_word_i, SPEC_BLOCK_BE);

   // Data operation classes, cache ops except OP_ICONG_INVAL folded into loads and stores
   logic op_user_zone;
   logic op_user_wr;
   logic op_priv_wr;
   logic op_touch;
   logic op_spec;

   always_comb
   begin
      op_user_zone = 1'b0;
      op_user_wr = 1'b0;
      op_priv_wr = 1'b0;
      op_touch = 1'b0;
      op_spec = 1'b0;
      case (d_op_i)
         OP_LOAD, OP_DBLK_FLUSH, OP_DBLK_STORE, OP_IBLK_INVAL:
         begin
            op_user_zone = 1'b1;
         end
         OP_STORE, OP_DBLK_ZERO:
         begin
            op_user_zone = 1'b1;
            op_user_wr = 1'b1;
            op_priv_wr = 1'b1;
         end
         OP_DBLK_INVAL, OP_DCONG_INVAL:
         begin
            op_priv_wr = 1'b1;
         end
         OP_TOUCH:
         begin
            op_user_zone = 1'b1;
            op_touch = 1'b1;
            op_spec = 1'b1;
         end
         OP_BLK_ALLOC:
         begin
            op_user_zone = 1'b1;
            op_user_wr = 1'b1;
            op_priv_wr = 1'b1;
            op_spec = 1'b1;
         end
         default:
         begin
            op_user_zone = 1'b0;
         end
      endcase
   end

   // Data protection and miss
   logic d_match;
   logic d_prot_viol;
   logic d_miss;

   assign d_match = d_hit_i &&
      tag_match(d_entry_process_tag_i, current_process_id_i);

   always_comb
   begin
      d_prot_viol = 1'b0;
      if (user_mode_flag_i)
      begin
         if (op_user_zone && d_zone == ZONE_NO_ACCESS)
         begin
            d_prot_viol = 1'b1;
         end
         if (op_user_wr && !d_store_permit && d_zone != ZONE_FORCE)
         begin
            d_prot_viol = 1'b1;
         end
         if (op_user_wr && d_user_attr && user_attr_fault_enable_i)
         begin
            d_prot_viol = 1'b1;
         end
      end
      else
      begin
         if (op_priv_wr && !d_store_permit &&
            d_zone != ZONE_PRIV_FORCE && d_zone != ZONE_FORCE)
         begin
            d_prot_viol = 1'b1;
         end
         if (op_priv_wr && d_user_attr && user_attr_fault_enable_i)
         begin
            d_prot_viol = 1'b1;
         end
      end
   end

   assign d_miss = !d_match && !op_touch;

   always_comb
   begin
      d_fault_o = FAULT_NONE;
      d_nop_o = 1'b0;
      d_go_o = 1'b0;
      if (d_req_i && d_op_i != OP_NONE)
      begin
         if (!data_relocate_ff)
         begin
            d_go_o = 1'b1;
         end
         else if (d_miss)
         begin
            d_fault_o = FAULT_DATA_MISS;
         end
         else if (!d_match || (d_prot_viol && op_spec))
         begin
            d_nop_o = 1'b1;
         end
         else if (d_prot_viol)
         begin
            d_fault_o = FAULT_DATA_STORAGE;
         end
         else
         begin
            d_go_o = 1'b1;
         end
      end
   end

   // Instruction fetch check
   logic i_match;
   logic i_viol;

   assign i_match = i_hit_i &&
      tag_match(i_entry_process_tag_i, current_process_id_i);

   always_comb
   begin
      i_viol = i_spec_block;
      if (user_mode_flag_i)
      begin
         if (i_zone == ZONE_NO_ACCESS ||
            (!i_run_permit && i_zone != ZONE_FORCE))
         begin
            i_viol = 1'b1;
         end
      end
      else if (!i_run_permit && i_zone != ZONE_PRIV_FORCE &&
         i_zone != ZONE_FORCE)
      begin
         i_viol = 1'b1;
      end
   end

   assign i_miss_o = i_req_i && instr_relocate_ff && !i_match;
   // Fault travels with the fetched word, not raised at fetch
   assign i_tag_fault_o = i_req_i && instr_relocate_ff && i_match &&
      i_viol;
   assign i_go_o = i_req_i && !i_miss_o;
   assign instr_storage_fault_o = ex_valid_i && ex_tag_fault_i;
endmodule

// file: mmu_access_protection_check_props.sv
// Assertion checker for the MMU access-protection check
`timescale 1ns/1ps
module mmu_access_protection_check_props
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Machine state
   input wire logic interrupt_take_i,
   input wire logic relocate_wr_i,
   input wire logic user_mode_flag_i,
   input wire logic instr_relocate_o,
   input wire logic data_relocate_o,
   // Special-register port
   input wire logic spr_read_i,
   input wire logic spr_write_i,
   input wire logic [mmu_prot_pkg::SPR_NUM_W-1:0] spr_num_i,
   input wire logic [31:0] spr_wdata_i,
   input wire logic [31:0] spr_rdata_o,
   input wire logic spr_hit_o,
   // Data and execution
   input wire logic d_req_i,
   input wire mmu_prot_pkg::data_op_t d_op_i,
   input wire logic d_go_o,
   input wire mmu_prot_pkg::data_fault_t d_fault_o,
   input wire logic ex_valid_i,
   input wire logic instr_storage_fault_o
);
   import mmu_prot_pkg::*;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic pw;
   assign pw = !user_mode_flag_i && spr_num_i == ZONE_OVERRIDE_SPR;
   a_irq_real_mode: assert property (
      interrupt_take_i |=> !instr_relocate_o && !data_relocate_o)
      else $error("relocate flag kept after interrupt");
   a_flags_hold: assert property (
      !interrupt_take_i && !relocate_wr_i
      |=> $stable({instr_relocate_o, data_relocate_o}))
      else $error("relocate flag changed unasked");
   a_real_quiet: assert property (
      d_req_i && !data_relocate_o |-> d_fault_o == FAULT_NONE)
      else $error("fault raised in real mode");
   a_priv_read: assert property (
      d_req_i && !user_mode_flag_i && d_op_i == OP_LOAD
      |-> d_fault_o != FAULT_DATA_STORAGE)
      else $error("privileged read denied");
   a_fault_at_exec: assert property (
      instr_storage_fault_o |-> ex_valid_i)
      else $error("fetch fault without execution");
   a_zone_read_back: assert property (
      (spr_write_i && pw) ##1 (spr_read_i && pw)
      |-> spr_rdata_o == $past(spr_wdata_i))
      else $error("zone register read back differs");
   a_user_spr_refused: assert property (
      spr_read_i && user_mode_flag_i |-> spr_rdata_o == '0 && !spr_hit_o)
      else $error("user access reached zone register");
   a_go_no_fault: assert property (
      d_go_o |-> d_fault_o == FAULT_NONE)
      else $error("access proceeds with fault");
   c_storage: cover property (d_req_i && d_fault_o == FAULT_DATA_STORAGE);
   c_miss: cover property (d_req_i && d_fault_o == FAULT_DATA_MISS);
   c_exec_fault: cover property (instr_storage_fault_o);
endmodule
bind mmu_access_protection_check mmu_access_protection_check_props u_props
(
   .ref_clk_i, .sys_rst_i, .interrupt_take_i, .relocate_wr_i,
   .user_mode_flag_i, .instr_relocate_o, .data_relocate_o, .spr_read_i,
   .spr_write_i, .spr_num_i, .spr_wdata_i, .spr_rdata_o, .spr_hit_o,
   .d_req_i, .d_op_i, .d_go_o, .d_fault_o, .ex_valid_i,
   .instr_storage_fault_o
);

// file: mmu_access_protection_check_test.sv
// Self-checking bench for the MMU access-protection check
`timescale 1ns/1ps
module mmu_access_protection_check_test;
   import mmu_prot_pkg::*;
   logic ref_clk_i = 0, sys_rst_i = 1, interrupt_take_i = 0;
   logic relocate_wr_i = 0, instr_relocate_i = 0, data_relocate_i = 0;
   logic user_mode_flag_i = 0, user_attr_fault_enable_i = 0;
   logic spr_read_i = 0, spr_write_i = 0, d_req_i = 0, d_hit_i = 1;
   logic i_req_i = 0, i_hit_i = 1, ex_valid_i = 0, ex_tag_fault_i = 0;
   logic [7:0] current_process_id_i = 8'h05, d_entry_process_tag_i = 8'h05;
   logic [7:0] i_entry_process_tag_i = 8'h05;
   logic [9:0] spr_num_i = 10'h3b0;
   logic [31:0] spr_wdata_i = 32'h0000_0000, spr_rdata_o;
   logic [31:0] d_entry_data_word_i, d_entry_tag_word_i;
   logic [3:0] zi = 4'h5;
   logic wp = 0, rp = 0, g = 0, ua = 0;
   logic instr_relocate_o, data_relocate_o, spr_hit_o, d_go_o, d_nop_o;
   logic i_go_o, i_miss_o, i_tag_fault_o, instr_storage_fault_o;
   data_op_t d_op_i = OP_LOAD;
   data_fault_t d_fault_o;
   int bad_count = 0, compares = 0;
   initial
   begin
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   mmu_access_protection_check u_mmu_access_protection_check
   (
      .ref_clk_i, .sys_rst_i, .interrupt_take_i, .relocate_wr_i,
      .instr_relocate_i, .data_relocate_i, .user_mode_flag_i,
      .user_attr_fault_enable_i, .current_process_id_i, .instr_relocate_o,
      .data_relocate_o, .spr_read_i, .spr_write_i, .spr_num_i, .spr_wdata_i,
      .spr_rdata_o, .spr_hit_o, .d_req_i, .d_op_i, .d_hit_i,
      .d_entry_process_tag_i, .d_entry_data_word_i, .d_entry_tag_word_i,
      .d_go_o, .d_nop_o, .d_fault_o, .i_req_i, .i_hit_i,
      .i_entry_process_tag_i, .i_entry_data_word_i(d_entry_data_word_i),
      .i_go_o, .i_miss_o, .i_tag_fault_o, .ex_valid_i, .ex_tag_fault_i,
      .instr_storage_fault_o
   );
   tlb_entry_model u_tlb_entry_model
   (
      .zone_idx_i(zi), .store_permit_i(wp), .run_permit_i(rp),
      .spec_block_i(g), .user_attr_i(ua), .data_word_o(d_entry_data_word_i),
      .tag_word_o(d_entry_tag_word_i)
   );
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task tick;
      @(posedge ref_clk_i);
      #2;
   endtask
   task zw(input logic [31:0] v);
      tick;
      user_mode_flag_i = 0;
      spr_write_i = 1;
      spr_wdata_i = v;
      tick;
      spr_write_i = 0;
   endtask
   task t_spr;
      spr_read_i = 1;
      #1 chk(spr_rdata_o, 32'h0000_0000);
      zw(32'h1234_abcd);
      #1 chk(spr_rdata_o, 32'h1234_abcd);
      chk(spr_hit_o, 1);
      user_mode_flag_i = 1;
      spr_write_i = 1;
      spr_wdata_i = 32'h5a5a_0f0f;
      #1 chk(spr_rdata_o, 32'h0000_0000);
      chk(spr_hit_o, 0);
      tick;
      user_mode_flag_i = 0;
      spr_num_i = 10'h3b1;
      #1 chk(spr_rdata_o, 32'h0000_0000);
      chk(spr_hit_o, 0);
      tick;
      spr_write_i = 0;
      spr_num_i = 10'h3b0;
      #1 chk(spr_rdata_o, 32'h1234_abcd);
      spr_read_i = 0;
      $display("spr test done");
   endtask
   task t_data;
      logic [31:0] v;
      data_fault_t e;
      relocate_wr_i = 1;
      data_relocate_i = 1;
      instr_relocate_i = 1;
      tick;
      relocate_wr_i = 0;
      chk({instr_relocate_o, data_relocate_o}, 2'b11);
      d_req_i = 1;
      for (int z = 0; z < 4; z++)
      begin
         v = 32'hffff_ffff;
         v[21:20] = z[1:0];
         zw(v);
         for (int um = 0; um < 2; um++)
         begin
            user_mode_flag_i = um[0];
            d_op_i = OP_LOAD;
            e = (um == 1 && z == 0) ? FAULT_DATA_STORAGE : FAULT_NONE;
            #1 chk(d_fault_o, e);
            d_op_i = OP_DBLK_FLUSH;
            #1 chk(d_fault_o, e);
            d_op_i = OP_STORE;
            e = (um ? z != 3 : z < 2) ? FAULT_DATA_STORAGE : FAULT_NONE;
            #1 chk(d_fault_o, e);
            chk(d_go_o, e == FAULT_NONE);
            wp = 1;
            ua = 1;
            user_attr_fault_enable_i = 1;
            #1 chk(d_fault_o, FAULT_DATA_STORAGE);
            wp = 0;
            ua = 0;
            user_attr_fault_enable_i = 0;
            d_op_i = OP_DBLK_INVAL;
            #1 chk(d_fault_o, um ? FAULT_NONE : e);
         end
      end
      $display("data test done");
   endtask
   task t_miss;
      user_mode_flag_i = 0;
      d_op_i = OP_LOAD;
      d_hit_i = 0;
      #1 chk(d_fault_o, FAULT_DATA_MISS);
      d_op_i = OP_TOUCH;
      #1 chk(d_fault_o, FAULT_NONE);
      chk(d_nop_o, 1);
      d_hit_i = 1;
      d_op_i = OP_LOAD;
      d_entry_process_tag_i = 8'h06;
      #1 chk(d_fault_o, FAULT_DATA_MISS);
      d_entry_process_tag_i = 8'h00;
      #1 chk(d_fault_o, FAULT_NONE);
      $display("miss test done");
   endtask
   task t_fetch;
      zw(32'hffcf_ffff);
      user_mode_flag_i = 1;
      d_op_i = OP_TOUCH;
      #1 chk(d_nop_o, 1);
      chk(d_fault_o, FAULT_NONE);
      d_op_i = OP_DBLK_ZERO;
      #1 chk(d_fault_o, FAULT_DATA_STORAGE);
      d_op_i = OP_LOAD;
      i_req_i = 1;
      rp = 1;
      #1 chk(i_tag_fault_o, 1);
      user_mode_flag_i = 0;
      #1 chk(i_tag_fault_o, 0);
      rp = 0;
      #1 chk(i_tag_fault_o, 1);
      rp = 1;
      g = 1;
      #1 chk(i_tag_fault_o, 1);
      g = 0;
      i_hit_i = 0;
      #1 chk(i_miss_o, 1);
      chk(i_go_o, 0);
      i_hit_i = 1;
      ex_tag_fault_i = 1;
      #1 chk(instr_storage_fault_o, 0);
      ex_valid_i = 1;
      #1 chk(instr_storage_fault_o, 1);
      ex_valid_i = 0;
      $display("fetch test done");
   endtask
   task t_irq;
      user_mode_flag_i = 1;
      interrupt_take_i = 1;
      relocate_wr_i = 1;
      tick;
      interrupt_take_i = 0;
      relocate_wr_i = 0;
      #1 chk({instr_relocate_o, data_relocate_o}, 2'b00);
      chk(d_fault_o, FAULT_NONE);
      i_hit_i = 0;
      #1 chk({i_miss_o, i_tag_fault_o}, 2'b00);
      $display("interrupt test done");
   endtask
   task results;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (5000) @(posedge ref_clk_i);
      bad_count++;
      results;
   end
   initial
   begin
      repeat (6) @(posedge ref_clk_i);
      #2;
      sys_rst_i = 0;
      tick;
      t_spr;
      t_data;
      t_miss;
      t_fetch;
      t_irq;
      results;
   end
endmodule

// file: mmu_prot_pkg.sv
// Constants and types for the MMU access-protection check
package mmu_prot_pkg;
   localparam int WORD_W = 32;
   localparam int ZONE_COUNT = 16;
   localparam int ZONE_FIELD_W = 2;
   localparam int ZONE_IDX_W = 4;
   localparam int PID_W = 8;
   localparam int SPR_NUM_W = 10;
   localparam logic [SPR_NUM_W-1:0] ZONE_OVERRIDE_SPR = 10'h3b0;
   localparam logic [WORD_W-1:0] ZONE_OVERRIDE_RST = 32'h0000_0000;
   // Big-endian bit numbers within the entry words
   localparam int STORE_PERMIT_BE = 23;
   localparam int ZONE_IDX_BE_MSB = 24;
   localparam int RUN_PERMIT_BE = 22;
   localparam int SPEC_BLOCK_BE = 31;
   localparam int USER_ATTR_BE = 27;
   localparam logic [PID_W-1:0] GLOBAL_TAG = 8'h00;
   localparam logic [1:0] ZONE_NO_ACCESS = 2'h0;
   localparam logic [1:0] ZONE_PRIV_FORCE = 2'h2;
   localparam logic [1:0] ZONE_FORCE = 2'h3;

   typedef enum logic [3:0] {
      OP_NONE, OP_LOAD, OP_STORE, OP_DBLK_FLUSH, OP_DBLK_STORE,
      OP_DBLK_ZERO, OP_IBLK_INVAL, OP_DBLK_INVAL, OP_DCONG_INVAL,
      OP_ICONG_INVAL, OP_TOUCH, OP_PRIV_LOAD, OP_BLK_ALLOC
   } data_op_t;

   typedef enum logic [1:0] {
      FAULT_NONE, FAULT_DATA_STORAGE, FAULT_DATA_MISS
   } data_fault_t;
endpackage

// file: tlb_entry_model.sv
// Matched-entry builder standing in for the lookup side
`timescale 1ns/1ps
module tlb_entry_model
(
   // Entry fields
   input wire logic [3:0] zone_idx_i,
   input wire logic store_permit_i,
   input wire logic run_permit_i,
   input wire logic spec_block_i,
   input wire logic user_attr_i,
   // Entry words
   output logic [31:0] data_word_o,
   output logic [31:0] tag_word_o
);
   always_comb
   begin
      data_word_o = 32'h0000_0000;
      data_word_o[31-23] = store_permit_i;
      data_word_o[31-24 -: 4] = zone_idx_i;
      data_word_o[31-22] = run_permit_i;
      data_word_o[31-31] = spec_block_i;
      tag_word_o = 32'h0000_0000;
      tag_word_o[31-27] = user_attr_i;
   end
endmodule

// file: zone_override_file.sv
// Zone override register with special-register access and zone lookup
`timescale 1ns/1ps
module zone_override_file
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Special-register access
   input wire logic spr_wr_i,
   input wire logic [31:0] spr_wdata_i,
   output logic [31:0] zone_reg_o,
   // Lookup
   zone_sel_if.provider zone_index_field
);
   import mmu_prot_pkg::*;

   logic [31:0] zone_override_reg_ff;
   logic [31:0] nxt_zone_override_reg;

   // Field n sits at big-endian bits 2n..2n+1
   function automatic logic [1:0] pick_zone(input logic [31:0] r,
      input logic [3:0] n);
      logic [4:0] lsb;
      lsb = 5'(5'd30 - {n, 1'b0});
      pick_zone = r[lsb +: 2];
   endfunction

   always_comb
   begin
      nxt_zone_override_reg = zone_override_reg_ff;
      if (spr_wr_i)
      begin
         nxt_zone_override_reg = spr_wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         zone_override_reg_ff <= ZONE_OVERRIDE_RST;
      end
      else
      begin
         zone_override_reg_ff <= nxt_zone_override_reg;
      end
   end

   assign zone_reg_o = zone_override_reg_ff;
   // Live register contents, no caching
   assign zone_index_field.d_zone = pick_zone(zone_override_reg_ff, zone_index_field.d_index);
   assign zone_index_field.i_zone = pick_zone(zone_override_reg_ff, zone_index_field.i_index);
endmodule

// file: zone_sel_if.sv
// Zone field lookup carrier between the check and the zone register
`timescale 1ns/1ps
interface zone_sel_if;
   logic [3:0] d_index;
   logic [1:0] d_zone;
   logic [3:0] i_index;
   logic [1:0] i_zone;
   modport requester (output d_index, output i_index,
      input d_zone, input i_zone);
   modport provider (input d_index, input i_index,
      output d_zone, output i_zone);
endinterface
